// [hw/slpc_defs.svh]
`ifndef SLPC_DEFS_SVH
`define SLPC_DEFS_SVH

// system clock and pwm timing
`define SLPC_CLK_PERIOD_NS  100
`define SLPC_PWM_BASE_NS    500000
`define SLPC_PWM_BASE_CYC   (`SLPC_PWM_BASE_NS / `SLPC_CLK_PERIOD_NS)
`define SLPC_PWM_CODE_MAX   3'h4
`define SLPC_PWM_STEPS_LOG2 8
`define SLPC_PWM_SPAN_MULT  16

// two-wire and three-wire framing
`define SLPC_START_ONES     4'h9
`define SLPC_LAST_BIT       4'h7
`define SLPC_SEP_BIT        4'h8

// register map
`define SLPC_NUM_REGS       7
`define SLPC_OFS_PERIOD     8'h00
`define SLPC_OFS_RED_LVL    8'h01
`define SLPC_OFS_GREEN_LVL  8'h02
`define SLPC_OFS_BLUE_LVL   8'h03
`define SLPC_OFS_RED1_DUTY  8'h04
`define SLPC_OFS_GREEN1_DUTY 8'h05
`define SLPC_OFS_BLUE1_DUTY 8'h06
`define SLPC_ADDR_WRAP      8'h0f
`define SLPC_RESET_VAL      8'h00
`define SLPC_PERIOD_MASK    8'h07

// field positions
`define SLPC_LEVEL_MSB      4
`define SLPC_FULL1_BIT      5
`define SLPC_FULL2_BIT      6
`define SLPC_FULL3_BIT      7

// input synchroniser
`define SLPC_NUM_PINS       7

`endif

// [hw/slpc_pkg.sv]
package slpc_pkg;

	// receiver phase within a frame
	typedef enum logic [1:0] {
		SLPC_ST_IDLE,
		SLPC_ST_SEL,
		SLPC_ST_ADDR,
		SLPC_ST_DATA
	} slpc_state_t;

	typedef logic [7:0] slpc_byte_t;

endpackage

// [hw/slpc_regfile.sv]
`timescale 1ns/1ps
`default_nettype none
`include "slpc_defs.svh"

module slpc_regfile #(
	parameter int NUM_REGS        = `SLPC_NUM_REGS,
	parameter int BASE_PERIOD_CYC = `SLPC_PWM_BASE_CYC
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rst_sync_n,
	input  wire logic                  wr_en,
	input  wire logic [7:0]            wr_addr,
	input  wire logic [7:0]            wr_data,
	output var  logic [NUM_REGS*8-1:0] regs_q,
	output var  logic [2:0]            drive_q
);

	localparam int CW = $clog2(BASE_PERIOD_CYC * `SLPC_PWM_SPAN_MULT + 1);
	localparam int PW = CW + `SLPC_PWM_STEPS_LOG2;

	logic [NUM_REGS*8-1:0] regs_d;

	////////////////////////////////////////////////////////////////////////////////
	// elaboration guard: the pwm reads every mapped register
	if (NUM_REGS != `SLPC_NUM_REGS || BASE_PERIOD_CYC < 1) begin : g_bad_size
		$error("slpc_regfile: unsupported parameter values");
	end

	////////////////////////////////////////////////////////////////////////////////
	// next value per register; offsets above the map are dropped silently
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
		always_comb begin
			regs_d[i*8 +: 8] = regs_q[i*8 +: 8];
			if (wr_en && wr_addr == 8'(i)) begin
				if (i == 0) begin
					regs_d[i*8 +: 8] = wr_data & `SLPC_PERIOD_MASK;
				end else begin
					regs_d[i*8 +: 8] = wr_data;
				end
			end
		end
	end

	// all registers clear at reset
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			regs_q <= '0;
		end else begin
			regs_q <= regs_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pwm period counter; undefined codes saturate at the longest period
	logic [2:0]    code_eff;
	logic [CW-1:0] period_cyc;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic [PW-1:0] phase;
	logic [2:0]    drive_d;

	always_comb begin
		code_eff   = (regs_q[2:0] > `SLPC_PWM_CODE_MAX) ? `SLPC_PWM_CODE_MAX : regs_q[2:0];
		period_cyc = CW'(BASE_PERIOD_CYC) << code_eff;
		// a shortened period mid-count wraps at once instead of running on
		cnt_d      = (cnt_q >= CW'(period_cyc - 1'b1)) ? '0 : CW'(cnt_q + 1'b1);
		phase      = {cnt_q, 8'h00};
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// exact compare cnt*256 < duty*period avoids a fractional prescaler
	for (genvar c = 0; c < 3; c++) begin : g_chan
		logic [PW-1:0] thresh;
		always_comb begin
			thresh     = PW'(regs_q[(4 + c)*8 +: 8]) * PW'(period_cyc);
			drive_d[c] = regs_q[(1 + c)*8 + `SLPC_FULL1_BIT] || (phase < thresh);
		end
	end

	// drives are registered so the top outputs come from flops
	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			drive_q <= 3'h0;
		end else begin
			drive_q <= drive_d;
		end
	end

	chk_period_wrap: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		cnt_q == '0 && $past(cnt_q) != '0 |-> $past(cnt_q) >= $past(period_cyc) - 1'b1)
		else $error("pwm counter wrapped early");

	chk_duty_zero: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		regs_q[39:32] == 8'h00 && !regs_q[8 + `SLPC_FULL1_BIT] && $stable(regs_q[39:32])
		&& $stable(regs_q[8 + `SLPC_FULL1_BIT]) |=> !drive_q[0])
		else $error("zero duty drove red output");

	chk_full_on: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		regs_q[8 + `SLPC_FULL1_BIT] |=> drive_q[0])
		else $error("force bit did not hold output on");

	////////////////////////////////////////////////////////////////////////////////
	chk_period_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		regs_q[7:3] == 5'h00)
		else $error("unused period bits are not zero");

	chk_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_sync_n)
		(wr_en && wr_addr == `SLPC_OFS_RED1_DUTY) |=> regs_q[39:32] == $past(wr_data))
		else $error("duty write did not land");

endmodule
`default_nettype wire

// [hw/slpc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "slpc_defs.svh"

module slpc_top #(
	parameter int BASE_PERIOD_CYC = `SLPC_PWM_BASE_CYC,
	parameter int NUM_REGS        = `SLPC_NUM_REGS
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       serial_clk,
	input  wire logic       serial_line,
	input  wire logic       frame_select,
	input  wire logic       wire_count_select,
	input  wire logic       addr_strap_2,
	input  wire logic       addr_strap_1,
	input  wire logic       addr_strap_0,
	output var  logic       red1_drive,
	output var  logic       green1_drive,
	output var  logic       blue1_drive,
	output var  logic       red2_full_on,
	output var  logic       red3_full_on,
	output var  logic       green2_full_on,
	output var  logic       green3_full_on,
	output var  logic       blue2_full_on,
	output var  logic       blue3_full_on,
	output var  logic [4:0] red_level_code,
	output var  logic [4:0] green_level_code,
	output var  logic [4:0] blue_level_code,
	output var  logic [2:0] period_code
);

	localparam int NP = `SLPC_NUM_PINS;

	////////////////////////////////////////////////////////////////////////////////
	// elaboration guard
	if (BASE_PERIOD_CYC < 1 || NUM_REGS != `SLPC_NUM_REGS) begin : g_bad_cfg
		$error("slpc_top: unsupported parameter values");
	end

	////////////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	logic rst_meta_q;
	logic rst_sync_n;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: three flops, value moves once stages two and three agree
	logic [NP-1:0] pin_raw;
	logic [NP-1:0] s1_q;
	logic [NP-1:0] s2_q;
	logic [NP-1:0] s3_q;
	logic [NP-1:0] filt_q;
	logic [NP-1:0] filt_d;

	assign pin_raw = {serial_clk, serial_line, frame_select, wire_count_select,
		addr_strap_2, addr_strap_1, addr_strap_0};

	for (genvar i = 0; i < NP; i++) begin : g_pin
		always_comb begin
			filt_d[i] = (s2_q[i] == s3_q[i]) ? s2_q[i] : filt_q[i];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			filt_q <= '0;
		end else begin
			s1_q   <= pin_raw;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= filt_d;
		end
	end

	logic       sck_rise;
	logic       data_f;
	logic       frame_f;
	logic       two_wire;
	logic [3:0] straps;

	// in two-wire mode the frame select pin doubles as strap 3
	assign sck_rise = filt_d[6] && !filt_q[6];
	assign data_f   = filt_q[5];
	assign frame_f  = filt_q[4];
	assign two_wire = filt_q[3];
	assign straps   = filt_q[4:0] == '0 ? 4'h0 : {filt_q[4], filt_q[2:0]};

	////////////////////////////////////////////////////////////////////////////////
	// decode helpers
	function automatic logic sel_match(input slpc_pkg::slpc_byte_t b, input logic full, input logic [3:0] st);
		if (full) begin
			sel_match = (b[7:5] == 3'h0) && (b[4:1] == st);
		end else begin
			sel_match = (b[7:4] == 4'h0) && (b[3:1] == st[2:0]);
		end
	endfunction

	function automatic slpc_pkg::slpc_byte_t addr_next(input slpc_pkg::slpc_byte_t a);
		addr_next = (a == `SLPC_ADDR_WRAP) ? 8'h00 : 8'(a + 8'h01);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// frame receiver
	slpc_pkg::slpc_state_t st_q;
	slpc_pkg::slpc_state_t st_d;
	logic [3:0]            bit_q;
	logic [3:0]            bit_d;
	logic [3:0]            ones_q;
	logic [3:0]            ones_d;
	logic [7:0]            shift_q;
	logic [7:0]            shift_d;
	logic [7:0]            addr_q;
	logic [7:0]            addr_d;
	logic                  wr_en_q;
	logic                  wr_en_d;
	logic [7:0]            wr_addr_q;
	logic [7:0]            wr_addr_d;
	logic [7:0]            wr_data_q;
	logic [7:0]            wr_data_d;
	logic                  byte_done;
	logic [7:0]            byte_v;
	logic                  start_hit;

	// a genuine frame never holds nine ones in a row, so a start cannot be faked
	assign start_hit = two_wire && sck_rise && !data_f && ones_q >= `SLPC_START_ONES;

	always_comb begin
		st_d      = st_q;
		bit_d     = bit_q;
		ones_d    = ones_q;
		shift_d   = shift_q;
		addr_d    = addr_q;
		wr_en_d   = 1'b0;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		byte_done = 1'b0;
		byte_v    = shift_q;
		if (!two_wire) begin
			ones_d = 4'h0;
			if (!frame_f) begin
				st_d  = slpc_pkg::SLPC_ST_SEL;
				bit_d = 4'h0;
			end else if (sck_rise && st_q != slpc_pkg::SLPC_ST_IDLE) begin
				shift_d = {shift_q[6:0], data_f};
				if (bit_q == `SLPC_LAST_BIT) begin
					byte_done = 1'b1;
					byte_v    = shift_d;
					bit_d     = 4'h0;
				end else begin
					bit_d = 4'(bit_q + 4'h1);
				end
			end
		end else if (sck_rise) begin
			if (data_f) begin
				ones_d = (ones_q >= `SLPC_START_ONES) ? ones_q : 4'(ones_q + 4'h1);
			end else begin
				ones_d = 4'h0;
			end
			if (start_hit) begin
				st_d  = slpc_pkg::SLPC_ST_SEL;
				bit_d = 4'h0;
			end else if (st_q != slpc_pkg::SLPC_ST_IDLE) begin
				if (bit_q < `SLPC_SEP_BIT) begin
					shift_d = {shift_q[6:0], data_f};
					bit_d   = 4'(bit_q + 4'h1);
				end else if (data_f) begin
					st_d = slpc_pkg::SLPC_ST_IDLE;
				end else begin
					byte_done = 1'b1;
					bit_d     = 4'h0;
				end
			end
		end
		if (byte_done) begin
			case (st_q)
				slpc_pkg::SLPC_ST_SEL: begin
					// mismatch parks the receiver until the next start
					st_d = sel_match(byte_v, two_wire, straps) ? slpc_pkg::SLPC_ST_ADDR
						: slpc_pkg::SLPC_ST_IDLE;
				end
				slpc_pkg::SLPC_ST_ADDR: begin
					addr_d = byte_v;
					st_d   = slpc_pkg::SLPC_ST_DATA;
				end
				slpc_pkg::SLPC_ST_DATA: begin
					wr_en_d   = 1'b1;
					wr_addr_d = addr_q;
					wr_data_d = byte_v;
					addr_d    = addr_next(addr_q);
				end
				default: begin
					st_d = slpc_pkg::SLPC_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			st_q      <= slpc_pkg::SLPC_ST_IDLE;
			bit_q     <= 4'h0;
			ones_q    <= 4'h0;
			shift_q   <= 8'h00;
			addr_q    <= 8'h00;
			wr_en_q   <= 1'b0;
			wr_addr_q <= 8'h00;
			wr_data_q <= 8'h00;
		end else begin
			st_q      <= st_d;
			bit_q     <= bit_d;
			ones_q    <= ones_d;
			shift_q   <= shift_d;
			addr_q    <= addr_d;
			wr_en_q   <= wr_en_d;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers; the pwm counter lives beside them
	logic [NUM_REGS*8-1:0] regs;
	logic [2:0]            chan_drive;

	slpc_regfile #(
		.NUM_REGS        (NUM_REGS),
		.BASE_PERIOD_CYC (BASE_PERIOD_CYC)
	) u_regs (
		.clk_sys    (clk_sys),
		.rst_sync_n (rst_sync_n),
		.wr_en      (wr_en_q),
		.wr_addr    (wr_addr_q),
		.wr_data    (wr_data_q),
		.regs_q     (regs),
		.drive_q    (chan_drive)
	);

	// level fields and force bits come straight from register flops
	assign period_code      = regs[2:0];
	assign red_level_code   = regs[8 +: 5];
	assign green_level_code = regs[16 +: 5];
	assign blue_level_code  = regs[24 +: 5];
	assign red2_full_on     = regs[8 + `SLPC_FULL2_BIT];
	assign red3_full_on     = regs[8 + `SLPC_FULL3_BIT];
	assign green2_full_on   = regs[16 + `SLPC_FULL2_BIT];
	assign green3_full_on   = regs[16 + `SLPC_FULL3_BIT];
	assign blue2_full_on    = regs[24 + `SLPC_FULL2_BIT];
	assign blue3_full_on    = regs[24 + `SLPC_FULL3_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// group one drives leave the register block from its flops
	assign red1_drive   = chan_drive[0];
	assign green1_drive = chan_drive[1];
	assign blue1_drive  = chan_drive[2];

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_sync_n);

	chk_start_arms: assert property (start_hit |=> st_q == slpc_pkg::SLPC_ST_SEL && bit_q == 4'h0)
		else $error("start pattern did not arm select phase");

	chk_sep_abort: assert property (two_wire && sck_rise && !start_hit && st_q != slpc_pkg::SLPC_ST_IDLE
		&& bit_q == `SLPC_SEP_BIT && data_f |=> st_q == slpc_pkg::SLPC_ST_IDLE && !wr_en_q)
		else $error("separator one did not abort frame");

	chk_sel_mismatch: assert property (byte_done && st_q == slpc_pkg::SLPC_ST_SEL
		&& !sel_match(byte_v, two_wire, straps) |=> st_q == slpc_pkg::SLPC_ST_IDLE)
		else $error("foreign select byte accepted");

	chk_sel_match: assert property (byte_done && st_q == slpc_pkg::SLPC_ST_SEL
		&& sel_match(byte_v, two_wire, straps) |=> st_q == slpc_pkg::SLPC_ST_ADDR)
		else $error("matching select byte rejected");

	chk_addr_latch: assert property (byte_done && st_q == slpc_pkg::SLPC_ST_ADDR
		|=> addr_q == $past(byte_v) && !wr_en_q)
		else $error("register address not latched");

	chk_data_write: assert property (byte_done && st_q == slpc_pkg::SLPC_ST_DATA
		|=> wr_en_q && wr_addr_q == $past(addr_q) && wr_data_q == $past(byte_v))
		else $error("data byte not written");

	chk_addr_wrap: assert property (wr_en_q |-> addr_q == addr_next(wr_addr_q))
		else $error("address did not advance after write");

	chk_wrap_zero: assert property (wr_en_q && wr_addr_q == `SLPC_ADDR_WRAP |-> addr_q == 8'h00)
		else $error("address past 0fh did not wrap");

	chk_write_only_data: assert property (wr_en_q |-> $past(st_q) == slpc_pkg::SLPC_ST_DATA)
		else $error("write outside data phase");

	cov_write: cover property (wr_en_q && two_wire);
	cov_burst_wrap: cover property (wr_en_q && wr_addr_q == `SLPC_ADDR_WRAP);
	cov_abort: cover property (st_q == slpc_pkg::SLPC_ST_DATA ##1 st_q == slpc_pkg::SLPC_ST_IDLE);
	cov_three_wire: cover property (wr_en_q && !two_wire);

endmodule
`default_nettype wire

// [tb/slpc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// host side of the serial link: it drives clock, data and the frame enable
module slpc_host_model #(
	parameter int HALF_CYC = 4
) (
	input  wire logic clk_sys,
	output var  logic serial_clk,
	output var  logic serial_line,
	output var  logic frame_select
);

	// link parks with its clock low; the enable doubles as strap 3 in two-wire mode
	initial begin
		serial_clk   = 1'b0;
		serial_line  = 1'b0;
		frame_select = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// data moves with the falling clock, so it is held a half period past the rise
	task automatic send_bit(input logic b);
		@(posedge clk_sys);
		serial_clk  <= 1'b0;
		serial_line <= b;
		repeat (HALF_CYC) @(posedge clk_sys);
		serial_clk <= 1'b1;
		repeat (HALF_CYC - 1) @(posedge clk_sys);
	endtask

	// nine ones then a zero restart the receiver from any state
	task automatic send_start();
		repeat (9) send_bit(1'b1);
		send_bit(1'b0);
	endtask

	// one byte msb first, then its separator bit
	task automatic send_byte(input logic [7:0] v, input logic sep);
		for (int i = 7; i >= 0; i--) begin
			send_bit(v[i]);
		end
		send_bit(sep);
	endtask

	// clock stands still between frames; data shows no stale value
	task automatic park(input int n);
		@(posedge clk_sys);
		serial_clk  <= 1'b0;
		serial_line <= ~serial_line;
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic set_strap3(input logic b);
		@(posedge clk_sys);
		frame_select <= b;
	endtask

	// three-wire frame: first n bits of v while the enable is high
	task automatic send_frame3(input logic [23:0] v, input int n);
		@(posedge clk_sys);
		frame_select <= 1'b1;
		for (int i = 23; i > 23 - n; i--) begin
			send_bit(v[i]);
		end
		park(2);
		frame_select <= 1'b0;
		repeat (12) @(posedge clk_sys);
	endtask

endmodule

`default_nettype wire

// [tb/slpc_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none

`define SLPC_CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module slpc_top_tb;

	localparam int         BASE = 16;
	localparam logic [7:0] SEL  = 8'h14;

	logic       clk_sys;
	logic       rst_n;
	logic       wire_count_select;
	logic [2:0] strap;
	logic       serial_clk;
	logic       serial_line;
	logic       frame_select;
	logic       red1_drive;
	logic       green1_drive;
	logic       blue1_drive;
	logic [5:0] full_on;
	logic [4:0] red_level_code;
	logic [4:0] green_level_code;
	logic [4:0] blue_level_code;
	logic [2:0] period_code;
	int         miscompares = 0;
	int         comparisons = 0;
	logic [10:0] bad [6] = '{{8'h16, 3'b000}, {8'h94, 3'b000}, {8'h04, 3'b000},
		{SEL, 3'b100}, {SEL, 3'b010}, {SEL, 3'b001}};

	// short base period keeps every pwm window small
	slpc_top #(.BASE_PERIOD_CYC(BASE)) slpc_top_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .serial_clk(serial_clk), .serial_line(serial_line),
		.frame_select(frame_select), .wire_count_select(wire_count_select),
		.addr_strap_2(strap[2]), .addr_strap_1(strap[1]), .addr_strap_0(strap[0]),
		.red1_drive(red1_drive), .green1_drive(green1_drive), .blue1_drive(blue1_drive),
		.red2_full_on(full_on[5]), .red3_full_on(full_on[4]), .green2_full_on(full_on[3]),
		.green3_full_on(full_on[2]), .blue2_full_on(full_on[1]), .blue3_full_on(full_on[0]),
		.red_level_code(red_level_code), .green_level_code(green_level_code),
		.blue_level_code(blue_level_code), .period_code(period_code)
	);

	slpc_host_model slpc_host_model_i (
		.clk_sys(clk_sys), .serial_clk(serial_clk), .serial_line(serial_line), .frame_select(frame_select)
	);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// whole two-wire write with chosen separators: select, address, data
	task automatic write2(input logic [7:0] sel, input logic [7:0] a, input logic [7:0] d, input logic [2:0] s);
		slpc_host_model_i.send_start();
		slpc_host_model_i.send_byte(sel, s[2]);
		slpc_host_model_i.send_byte(a, s[1]);
		slpc_host_model_i.send_byte(d, s[0]);
		slpc_host_model_i.park(8);
	endtask

	// high cycles of the group-one drives, sampled mid-cycle where they are settled
	task automatic count_high(input int n, output int r, output int g, output int b);
		r = 0;
		g = 0;
		b = 0;
		repeat (n) begin
			@(negedge clk_sys);
			if (red1_drive === 1'b1) r++;
			if (green1_drive === 1'b1) g++;
			if (blue1_drive === 1'b1) b++;
		end
	endtask

	// watchdog: the whole sequence needs well under this many cycles
	initial begin
		repeat (60000) @(posedge clk_sys);
		miscompares++;
		stop_test();
	end

	initial begin
		int r;
		int g;
		int b;
		rst_n             = 1'b0;
		wire_count_select = 1'b1;
		strap             = 3'b010;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		`SLPC_CHK(period_code, 3'h0)
		`SLPC_CHK({red_level_code, green_level_code, blue_level_code}, 15'h0000)
		`SLPC_CHK(full_on, 6'h00)
		`SLPC_CHK({red1_drive, green1_drive, blue1_drive}, 3'h0)
		$display("test reset done");
		repeat (1001) @(posedge clk_sys);

		// burst from 01h: address steps after each byte
		slpc_host_model_i.send_start();
		slpc_host_model_i.send_byte(SEL, 1'b0);
		slpc_host_model_i.send_byte(8'h01, 1'b0);
		slpc_host_model_i.send_byte(8'he5, 1'b0);
		slpc_host_model_i.send_byte(8'h4a, 1'b0);
		slpc_host_model_i.send_byte(8'h9f, 1'b0);
		slpc_host_model_i.park(8);
		`SLPC_CHK({red_level_code, green_level_code, blue_level_code}, {5'h05, 5'h0a, 5'h1f})
		`SLPC_CHK(full_on, 6'b11_10_01)
		`SLPC_CHK(red1_drive, 1'b1)
		$display("test burst done");

		// burst from 0fh wraps to 00h, then 01h
		slpc_host_model_i.send_start();
		slpc_host_model_i.send_byte(SEL, 1'b0);
		slpc_host_model_i.send_byte(8'h0f, 1'b0);
		slpc_host_model_i.send_byte(8'h11, 1'b0);
		slpc_host_model_i.send_byte(8'hfc, 1'b0);
		slpc_host_model_i.send_byte(8'h00, 1'b0);
		slpc_host_model_i.park(8);
		`SLPC_CHK(period_code, 3'h4)
		`SLPC_CHK({red_level_code, full_on[5:4]}, 7'h00)
		$display("test wrap done");

		// refused frames must leave blue untouched
		foreach (bad[i]) begin
			write2(bad[i][10:3], 8'h03, 8'h00, bad[i][2:0]);
			`SLPC_CHK({blue_level_code, full_on[1:0]}, 7'b11111_01)
		end
		slpc_host_model_i.send_byte(SEL, 1'b0);
		slpc_host_model_i.send_byte(8'h03, 1'b0);
		slpc_host_model_i.send_byte(8'h00, 1'b0);
		slpc_host_model_i.park(8);
		`SLPC_CHK(blue_level_code, 5'h1f)
		// restart in mid-frame; select bit 0 is a don't-care
		slpc_host_model_i.send_start();
		slpc_host_model_i.send_byte(SEL, 1'b0);
		repeat (3) slpc_host_model_i.send_bit(1'b1);
		write2(8'h15, 8'h03, 8'h00, 3'b000);
		`SLPC_CHK({blue_level_code, full_on[1:0]}, 7'h00)
		// rewired straps move the select byte the device answers to
		strap <= 3'b101;
		write2(SEL, 8'h03, 8'h9f, 3'b000);
		`SLPC_CHK({blue_level_code, full_on[1:0]}, 7'h00)
		write2(8'h1b, 8'h03, 8'h81, 3'b000);
		`SLPC_CHK({blue_level_code, full_on[1:0]}, 7'b00001_01)
		strap <= 3'b010;
		$display("test refuse done");

		// pwm: on-time is duty/256 of a period that doubles per code
		slpc_host_model_i.send_start();
		slpc_host_model_i.send_byte(SEL, 1'b0);
		slpc_host_model_i.send_byte(8'h04, 1'b0);
		slpc_host_model_i.send_byte(8'h80, 1'b0);
		slpc_host_model_i.send_byte(8'h40, 1'b0);
		slpc_host_model_i.send_byte(8'h00, 1'b0);
		slpc_host_model_i.park(8);
		for (int code = 0; code < 5; code++) begin
			write2(SEL, 8'h00, 8'(code), 3'b000);
			`SLPC_CHK(period_code, 3'(code))
			repeat (512) @(posedge clk_sys);
			count_high(BASE << code, r, g, b);
			`SLPC_CHK(r, 8 << code)
			`SLPC_CHK(g, 4 << code)
			`SLPC_CHK(b, 0)
		end
		// codes above four keep the longest period
		write2(SEL, 8'h00, 8'h07, 3'b000);
		`SLPC_CHK(period_code, 3'h7)
		write2(SEL, 8'h06, 8'hff, 3'b000);
		write2(SEL, 8'h01, 8'h20, 3'b000);
		repeat (512) @(posedge clk_sys);
		count_high(BASE << 4, r, g, b);
		`SLPC_CHK(r, BASE << 4)
		`SLPC_CHK(b, (BASE << 4) - 1)
		$display("test pwm done");

		// three-wire: 24 clocks write, 23 do not, two-wire select refused
		slpc_host_model_i.set_strap3(1'b0);
		wire_count_select <= 1'b0;
		repeat (8) @(posedge clk_sys);
		slpc_host_model_i.send_frame3({8'h04, 8'h02, 8'h73}, 24);
		`SLPC_CHK({green_level_code, full_on[3:2]}, 7'b10011_10)
		slpc_host_model_i.send_frame3({8'h04, 8'h02, 8'h00}, 23);
		`SLPC_CHK(green_level_code, 5'h13)
		slpc_host_model_i.send_frame3({8'h14, 8'h02, 8'h00}, 24);
		`SLPC_CHK(green_level_code, 5'h13)
		$display("test three_wire done");
		stop_test();
	end

endmodule

`default_nettype wire
